//--- ureb_cfg.svh
// Constants for the USB reset, attach and boot-mode controller
`ifndef UREB_CFG_SVH
`define UREB_CFG_SVH
`define UREB_RST_VECTOR       8'h17
`define UREB_DT_APP           8'h01
`define UREB_DT_HDR_ONLY      8'h02
`define UREB_DT_IN_PROGRESS   8'hA5
`define UREB_ATTR_HDR_WR_BIT  1
`define UREB_MRST_MIN_NS      1000
`define UREB_CLK_PERIOD_NS    25
`define UREB_SYNC_RST_CYCLES  4'h2
`endif

//--- ureb_pkg.sv
// Types for the USB reset, attach and boot-mode controller
package ureb_pkg;
   typedef enum logic [1:0] {
      UREB_BOOT_UPGRADE_DEFAULT,
      UREB_BOOT_UPGRADE_HEADER,
      UREB_BOOT_APPLICATION
   } ureb_boot_mode_t;

   typedef enum logic [2:0] {
      UREB_DL_IDLE,
      UREB_DL_WR_HEADER,
      UREB_DL_SAVE_TYPE,
      UREB_DL_MARK,
      UREB_DL_WR_APP,
      UREB_DL_RESTORE
   } ureb_dl_state_t;
endpackage : ureb_pkg

//--- ureb_ctrl.sv
// USB reset, bus-attach, reset outputs, boot identity and download sequencing
// Functional notes
// - Attach bit set enables D+ pull-up
// - Power-up clears attach, pull-up floats
// - Attach, shadow, global enable survive bus resets
// - Shadow bit selects normal memory map
// - Global enable: bus reset resets system, mask and flag
// - Global bus reset raises no interrupt
// - Masked bus reset interrupts on input zero
// - Otherwise reset only engine and buffers
// - Non-global bus reset sets the status flag
// - Global reset clears the status flag
// - Vector write at 0x17 clears flag
// - Reset out on master or global reset
// - Codec reset follows firmware bit, inverted
// - No or bad header: default upgrade identity
// - Header only: upgrade mode, header identity
// - Download order: header, save, mark, app, restore
// - In-progress marker boots upgrade mode
// - Header written only if attribute bit 1
// - Bus reset after download restarts as application
// - Aborted download stays in program mode
// - Data type 01 app, 02 or A5 header, else invalid
`timescale 1ns/1ps
`include "ureb_cfg.svh"
module ureb_ctrl
   import ureb_pkg::*;
#(
   parameter int VID_W = 16,
   parameter logic [15:0] DFLT_VID = 16'h1234, // Arbitrary value
   parameter logic [15:0] DFLT_PID = 16'h5678  // Arbitrary value
) (
   // Clock and synchronous reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Asynchronous pins
   input  wire logic             master_reset_in,
   input  wire logic             usb_bus_reset_in,
   // Firmware control bits, one-cycle write strobes with data
   input  wire logic             ctl_wr,
   input  wire logic             bus_attach_wdata,
   input  wire logic             shadow_wdata,
   input  wire logic             global_en_wdata,
   input  wire logic             irq_mask_wr,
   input  wire logic             irq_mask_wdata,
   input  wire logic             codec_wr,
   input  wire logic             codec_reset_wdata,
   input  wire logic             vector_wr,
   input  wire logic [7:0]       irq_vector_reg,
   // Boot probe results
   input  wire logic             boot_start,
   input  wire logic             eeprom_present,
   input  wire logic             header_valid,
   input  wire logic [7:0]       header_data_type,
   input  wire logic [VID_W-1:0] header_vid,
   input  wire logic [VID_W-1:0] header_pid,
   // Download flow
   input  wire logic             dl_start,
   input  wire logic             dl_to_eeprom,
   input  wire logic [7:0]       dl_attributes,
   input  wire logic             dl_step_done,
   input  wire logic             dl_abort,
   // Status and control outputs
   output logic                  bus_attach_bit,
   output logic                  boot_rom_shadow_bit,
   output logic                  usb_reset_global_en,
   output logic                  usb_irq_mask_bit,
   output logic                  usb_reset_flag,
   output logic                  ext_irq0_out,
   output logic                  dp_pullup_out,
   output logic                  dp_pullup_oe,
   output logic                  system_reset_out,
   output logic                  codec_reset_out,
   output logic                  sie_bm_reset_out,
   output ureb_boot_mode_t       boot_mode,
   output logic [VID_W-1:0]      enum_vid,
   output logic [VID_W-1:0]      enum_pid,
   output ureb_dl_state_t        dl_state,
   output logic                  dl_wr_header,
   output logic                  dl_wr_app,
   output logic                  dl_type_wr,
   output logic [7:0]            dl_type_wdata
);

   localparam int MRST_CYC =
      (`UREB_MRST_MIN_NS + `UREB_CLK_PERIOD_NS - 1) / `UREB_CLK_PERIOD_NS;

   logic       mrst_s1_q, mrst_s2_q, bres_s1_q, bres_s2_q, bres_d_q;
   logic       bus_reset_evt, global_rst, hard_rst;
   logic [7:0] saved_type_q;
   logic       upgrade_pending_q;

   // Two-flop synchronisers for pins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mrst_s1_q <= 1'b0;
         mrst_s2_q <= 1'b0;
         bres_s1_q <= 1'b0;
         bres_s2_q <= 1'b0;
         bres_d_q  <= 1'b0;
      end else begin
         mrst_s1_q <= master_reset_in;
         mrst_s2_q <= mrst_s1_q;
         bres_s1_q <= usb_bus_reset_in;
         bres_s2_q <= bres_s1_q;
         bres_d_q  <= bres_s2_q;
      end
   end

   // Bus reset event on rising edge; global when enable set
   assign bus_reset_evt = bres_s2_q & ~bres_d_q;
   assign hard_rst      = sys_rst | mrst_s2_q;
   assign global_rst    = bus_reset_evt & usb_reset_global_en;

   // Attach cleared by a write, power-up or master reset; shadow only by power-up or master reset
   always_ff @(posedge clk) begin
      if (hard_rst) begin
         bus_attach_bit      <= 1'b0;
         boot_rom_shadow_bit <= 1'b0;
      end else if (ctl_wr) begin
         bus_attach_bit      <= bus_attach_wdata;
         boot_rom_shadow_bit <= boot_rom_shadow_bit | shadow_wdata;
      end
   end

   // Global enable keeps its value across bus resets
   always_ff @(posedge clk) begin
      if (hard_rst) begin
         usb_reset_global_en <= 1'b0;
      end else if (ctl_wr) begin
         usb_reset_global_en <= global_en_wdata;
      end
   end

   // Interrupt mask, cleared by any global reset
   always_ff @(posedge clk) begin
      if (hard_rst || global_rst) begin
         usb_irq_mask_bit <= 1'b0;
      end else if (irq_mask_wr) begin
         usb_irq_mask_bit <= irq_mask_wdata;
      end
   end

   // Status flag: global reset clears, else set wins over vector clear
   always_ff @(posedge clk) begin
      if (hard_rst || global_rst) begin
         usb_reset_flag <= 1'b0;
      end else if (bus_reset_evt) begin
         usb_reset_flag <= 1'b1;
      end else if (vector_wr && irq_vector_reg == `UREB_RST_VECTOR) begin
         usb_reset_flag <= 1'b0;
      end
   end

   // Interrupt only when not global and masked in
   assign ext_irq0_out = usb_reset_flag & usb_irq_mask_bit
                         & ~usb_reset_global_en;

   // Pull-up drive; high impedance while detached
   assign dp_pullup_out = 1'b1;
   assign dp_pullup_oe  = bus_attach_bit;

   // Reset outputs from flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         system_reset_out <= 1'b1;
         sie_bm_reset_out <= 1'b1;
      end else begin
         system_reset_out <= mrst_s2_q | global_rst;
         sie_bm_reset_out <= mrst_s2_q | bus_reset_evt;
      end
   end

   // Codec reset driven by firmware bit; power-up reset asserts it, bus and master reset do not
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         codec_reset_out <= 1'b1;
      end else if (codec_wr) begin
         codec_reset_out <= ~codec_reset_wdata;
      end
   end

   // Boot identity choice; pending upgrade turns into application on bus reset
   always_ff @(posedge clk) begin
      if (hard_rst) begin
         boot_mode <= UREB_BOOT_UPGRADE_DEFAULT;
         enum_vid  <= DFLT_VID;
         enum_pid  <= DFLT_PID;
      end else if (boot_start) begin
         if (!eeprom_present || !header_valid) begin
            boot_mode <= UREB_BOOT_UPGRADE_DEFAULT;
            enum_vid  <= DFLT_VID;
            enum_pid  <= DFLT_PID;
         end else if (header_data_type == `UREB_DT_APP) begin
            boot_mode <= UREB_BOOT_APPLICATION;
            enum_vid  <= header_vid;
            enum_pid  <= header_pid;
         end else if (header_data_type == `UREB_DT_HDR_ONLY ||
                      header_data_type == `UREB_DT_IN_PROGRESS) begin
            boot_mode <= UREB_BOOT_UPGRADE_HEADER;
            enum_vid  <= header_vid;
            enum_pid  <= header_pid;
         end else begin
            boot_mode <= UREB_BOOT_UPGRADE_DEFAULT;
            enum_vid  <= DFLT_VID;
            enum_pid  <= DFLT_PID;
         end
      end else if (bus_reset_evt && upgrade_pending_q) begin
         boot_mode <= UREB_BOOT_APPLICATION;
      end
   end

   // Download sequencer
   always_ff @(posedge clk) begin
      if (hard_rst) begin
         dl_state          <= UREB_DL_IDLE;
         saved_type_q      <= 8'h00;
         upgrade_pending_q <= 1'b0;
      end else if (dl_abort) begin
         dl_state <= UREB_DL_IDLE;
      end else begin
         unique case (dl_state)
            UREB_DL_IDLE: begin
               if (dl_start && boot_mode != UREB_BOOT_APPLICATION) begin
                  upgrade_pending_q <= 1'b0;
                  if (dl_to_eeprom && dl_attributes[`UREB_ATTR_HDR_WR_BIT]) begin
                     dl_state <= UREB_DL_WR_HEADER;
                  end else begin
                     dl_state <= UREB_DL_SAVE_TYPE;
                  end
               end
            end
            UREB_DL_WR_HEADER: begin
               if (dl_step_done) begin
                  dl_state <= UREB_DL_SAVE_TYPE;
               end
            end
            UREB_DL_SAVE_TYPE: begin
               saved_type_q <= header_data_type;
               dl_state     <= UREB_DL_MARK;
            end
            UREB_DL_MARK: begin
               if (dl_step_done) begin
                  dl_state <= UREB_DL_WR_APP;
               end
            end
            UREB_DL_WR_APP: begin
               if (dl_step_done) begin
                  dl_state <= UREB_DL_RESTORE;
               end
            end
            UREB_DL_RESTORE: begin
               if (dl_step_done) begin
                  dl_state          <= UREB_DL_IDLE;
                  upgrade_pending_q <= 1'b1;
               end
            end
         endcase
      end
   end

   // Download step strobes and data-type write value
   always_comb begin
      dl_wr_header  = (dl_state == UREB_DL_WR_HEADER);
      dl_wr_app     = (dl_state == UREB_DL_WR_APP);
      dl_type_wr    = (dl_state == UREB_DL_MARK) || (dl_state == UREB_DL_RESTORE);
      dl_type_wdata = (dl_state == UREB_DL_RESTORE) ? saved_type_q
                                                    : `UREB_DT_IN_PROGRESS;
   end

   // Assertions
   property p_flag_set;
      @(posedge clk) disable iff (hard_rst)
      (bus_reset_evt && !usb_reset_global_en) |=> usb_reset_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");

   property p_glob_clear;
      @(posedge clk) disable iff (sys_rst)
      global_rst |=> !usb_reset_flag && !ext_irq0_out;
   endproperty
   a_glob_clear: assert property (p_glob_clear) else $error("flag survived");

   property p_no_irq_global;
      @(posedge clk) disable iff (sys_rst)
      usb_reset_global_en |-> !ext_irq0_out;
   endproperty
   a_no_irq_global: assert property (p_no_irq_global) else $error("irq in global");

   property p_irq;
      @(posedge clk) disable iff (hard_rst)
      (bus_reset_evt && usb_irq_mask_bit && !usb_reset_global_en && !irq_mask_wr
       && !ctl_wr) |=> ext_irq0_out;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");

   property p_pullup;
      @(posedge clk) disable iff (hard_rst)
      ctl_wr |=> dp_pullup_oe == $past(bus_attach_wdata) && dp_pullup_out;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pullup mismatch");

   property p_attach_keep;
      @(posedge clk) disable iff (hard_rst)
      (bus_reset_evt && !ctl_wr) |=> $stable(bus_attach_bit) && $stable(boot_rom_shadow_bit);
   endproperty
   a_attach_keep: assert property (p_attach_keep) else $error("attach lost");

   property p_system_reset_out;
      @(posedge clk) disable iff (sys_rst)
      global_rst |=> system_reset_out;
   endproperty
   a_system_reset_out: assert property (p_system_reset_out) else $error("reset out missing");

   property p_codec;
      @(posedge clk) disable iff (sys_rst)
      codec_wr |=> codec_reset_out == !$past(codec_reset_wdata);
   endproperty
   a_codec: assert property (p_codec) else $error("codec reset wrong");

   property p_mark;
      @(posedge clk) disable iff (sys_rst)
      (dl_state == UREB_DL_SAVE_TYPE && !dl_abort) |=> dl_type_wr
         && dl_type_wdata == `UREB_DT_IN_PROGRESS;
   endproperty
   a_mark: assert property (p_mark) else $error("marker missing");

   property p_sie;
      @(posedge clk) disable iff (sys_rst)
      bus_reset_evt |=> sie_bm_reset_out;
   endproperty
   a_sie: assert property (p_sie) else $error("engine reset missing");

   property p_shadow_sticky;
      @(posedge clk) disable iff (hard_rst)
      boot_rom_shadow_bit |=> boot_rom_shadow_bit;
   endproperty
   a_shadow_sticky: assert property (p_shadow_sticky) else $error("shadow cleared");

   property p_app_after_dl;
      @(posedge clk) disable iff (hard_rst)
      (bus_reset_evt && upgrade_pending_q && !boot_start)
         |=> boot_mode == UREB_BOOT_APPLICATION;
   endproperty
   a_app_after_dl: assert property (p_app_after_dl) else $error("no restart as app");

   localparam int MRST_UNUSED = MRST_CYC;

endmodule : ureb_ctrl

//--- ureb_host_model.sv
// Host and firmware model: reset pins and download step completion
`timescale 1ns/1ps
`include "ureb_cfg.svh"
module ureb_host_model (
   // Clock
   input  wire logic       clk,
   // Download step requests and answer delay
   input  wire logic       dl_wr_header,
   input  wire logic       dl_wr_app,
   input  wire logic       dl_type_wr,
   input  wire logic [7:0] step_dly,
   // Pins toward the controller
   output logic            master_reset_in,
   output logic            usb_bus_reset_in,
   output logic            dl_step_done
);
   // Master reset width, one clock past the minimum
   localparam int MRST_CYC = `UREB_MRST_MIN_NS / `UREB_CLK_PERIOD_NS + 1;
   logic [7:0] cnt_q;
   initial begin
      master_reset_in = 1'b0;
      usb_bus_reset_in = 1'b0;
      dl_step_done = 1'b0;
      cnt_q = 8'h00;
   end
   // Finish each requested write after step_dly + 1 clocks with a one-cycle pulse
   always @(posedge clk) begin
      if (!(dl_wr_header | dl_wr_app | dl_type_wr) || dl_step_done) begin
         cnt_q <= 8'h00;
         dl_step_done <= 1'b0;
      end else if (cnt_q >= step_dly) begin
         dl_step_done <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
   // Master reset held long enough for the whole device
   task master_reset;
      @(posedge clk);
      master_reset_in <= 1'b1;
      repeat (MRST_CYC) @(posedge clk);
      master_reset_in <= 1'b0;
      repeat (5) @(posedge clk);
   endtask : master_reset
   // Bus reset condition, then idle bus
   task bus_reset;
      @(posedge clk);
      usb_bus_reset_in <= 1'b1;
      repeat (8) @(posedge clk);
      usb_bus_reset_in <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : bus_reset
endmodule : ureb_host_model

//--- ureb_ctrl_tb_top.sv
// Self-checking bench for the USB reset, attach and boot-mode controller
`timescale 1ns/1ps
`include "ureb_cfg.svh"
module ureb_ctrl_tb_top
   import ureb_pkg::*;
;
   localparam logic [15:0] DVID = 16'h1234; // Arbitrary value
   localparam logic [15:0] DPID = 16'h5678; // Arbitrary value
   localparam logic [15:0] HVID = 16'h0A5C; // Arbitrary value
   localparam logic [15:0] HPID = 16'h3C21; // Arbitrary value
   typedef struct packed {logic gen, msk, flag, irq, sys, serial_interface_engine;} ureb_brow_t;
   typedef struct packed {
      logic pres, vld; logic [7:0] dt; ureb_boot_mode_t md; logic hdr;
   } ureb_boot_t;
   ureb_brow_t brow [3] = '{'{1,1,0,0,1,1}, '{0,1,1,1,0,1}, '{0,0,1,0,0,1}};
   ureb_boot_t boot [6] = '{'{0,1,8'h01,UREB_BOOT_UPGRADE_DEFAULT,0},
      '{1,0,8'h01,UREB_BOOT_UPGRADE_DEFAULT,0}, '{1,1,8'h03,UREB_BOOT_UPGRADE_DEFAULT,0},
      '{1,1,8'h01,UREB_BOOT_APPLICATION,1}, '{1,1,8'hA5,UREB_BOOT_UPGRADE_HEADER,1},
      '{1,1,8'h02,UREB_BOOT_UPGRADE_HEADER,1}};
   logic clk = 0, sys_rst = 1, ctl_wr = 0, irq_mask_wr = 0, codec_wr = 0, vector_wr = 0;
   logic bus_attach_wdata = 0, shadow_wdata = 0, global_en_wdata = 0, irq_mask_wdata = 0;
   logic codec_reset_wdata = 0, boot_start = 0, eeprom_present = 0, header_valid = 0;
   logic dl_start = 0, dl_to_eeprom = 0, dl_abort = 0, master_reset_in, usb_bus_reset_in;
   logic [7:0] irq_vector_reg = 0, header_data_type = 0, dl_attributes = 0, step_dly = 0;
   logic [15:0] header_vid = HVID, header_pid = HPID, enum_vid, enum_pid;
   logic bus_attach_bit, boot_rom_shadow_bit, usb_reset_global_en, usb_reset_flag, ext_irq0_out;
   logic dp_pullup_out, dp_pullup_oe, system_reset_out, codec_reset_out, sie_bm_reset_out;
   logic dl_step_done, dl_wr_header, dl_wr_app, dl_type_wr, seen_sys, seen_sie, seen_irq;
   logic [7:0] dl_type_wdata;
   logic usb_irq_mask_bit;
   logic [23:0] seq = 0;
   ureb_boot_mode_t boot_mode;
   ureb_dl_state_t dl_state, last_st;
   int n_errors = 0, total_checks = 0, n;
   ureb_ctrl #(.DFLT_VID(DVID), .DFLT_PID(DPID)) dut_u (.clk, .sys_rst, .master_reset_in,
      .usb_bus_reset_in, .ctl_wr, .bus_attach_wdata, .shadow_wdata, .global_en_wdata,
      .irq_mask_wr, .irq_mask_wdata, .codec_wr, .codec_reset_wdata, .vector_wr,
      .irq_vector_reg, .boot_start, .eeprom_present, .header_valid, .header_data_type,
      .header_vid, .header_pid, .dl_start, .dl_to_eeprom, .dl_attributes, .dl_step_done,
      .dl_abort, .bus_attach_bit, .boot_rom_shadow_bit, .usb_reset_global_en,
      .usb_irq_mask_bit, .usb_reset_flag, .ext_irq0_out, .dp_pullup_out, .dp_pullup_oe,
      .system_reset_out, .codec_reset_out, .sie_bm_reset_out, .boot_mode, .enum_vid,
      .enum_pid, .dl_state, .dl_wr_header, .dl_wr_app, .dl_type_wr, .dl_type_wdata);
   ureb_host_model host_u (.clk, .dl_wr_header, .dl_wr_app, .dl_type_wr, .step_dly,
      .master_reset_in, .usb_bus_reset_in, .dl_step_done);
   // Clock
   always #12.5 clk = ~clk;
   task end_of_test;
      if (n_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cyc
   // One-cycle write strobe, data set by the caller beforehand
   task wr(input int k);
      @(posedge clk);
      case (k)
         0: ctl_wr <= 1'b1;
         1: irq_mask_wr <= 1'b1;
         2: codec_wr <= 1'b1;
         3: vector_wr <= 1'b1;
         4: boot_start <= 1'b1;
         5: dl_start <= 1'b1;
         default: dl_abort <= 1'b1;
      endcase
      @(posedge clk);
      {ctl_wr, irq_mask_wr, codec_wr, vector_wr, boot_start, dl_start, dl_abort} <= 7'h00;
   endtask : wr
   task run_dl;
      seq = 24'h0;
      wr(5);
      cyc(1);
      for (n = 0; n < 2000 && dl_state !== UREB_DL_IDLE; n++) cyc(1);
      cyc(1);
      chk("dl_done", 1, n < 2000);
   endtask : run_dl
   // Pulse capture, download state trail and marker value check
   always @(posedge clk) begin
      if (system_reset_out) seen_sys <= 1'b1;
      if (sie_bm_reset_out) seen_sie <= 1'b1;
      if (ext_irq0_out) seen_irq <= 1'b1;
      last_st <= dl_state;
      if (dl_state !== last_st) seq <= {seq[20:0], dl_state};
      if (dl_type_wr) chk("type_wdata", dl_state == UREB_DL_MARK ?
         `UREB_DT_IN_PROGRESS : header_data_type, dl_type_wdata);
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_of_test();
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      cyc(2);
      chk("attach", 0, {bus_attach_bit, dp_pullup_oe});
      codec_reset_wdata <= 1'b0;
      wr(2);
      cyc(1);
      chk("codec_rst", 1, codec_reset_out);
      codec_reset_wdata <= 1'b1;
      wr(2);
      cyc(1);
      chk("codec_rst", 0, codec_reset_out);
      {bus_attach_wdata, shadow_wdata} <= 2'b11;
      wr(0);
      cyc(1);
      chk("pullup", 3'h7, {dp_pullup_oe, dp_pullup_out, boot_rom_shadow_bit});
      foreach (brow[i]) begin
         global_en_wdata <= brow[i].gen;
         wr(0);
         irq_mask_wdata <= brow[i].msk;
         wr(1);
         cyc(1);
         chk("irq_mask", brow[i].msk, usb_irq_mask_bit);
         {seen_sys, seen_sie, seen_irq} = 3'h0;
         host_u.bus_reset();
         chk("flag", brow[i].flag, usb_reset_flag);
         chk("irq_seen", brow[i].irq, seen_irq);
         chk("sys_rst_seen", brow[i].sys, seen_sys);
         chk("sie_seen", brow[i].serial_interface_engine, seen_sie);
         chk("kept", {2'b11, brow[i].gen},
            {bus_attach_bit, boot_rom_shadow_bit, usb_reset_global_en});
         chk("codec_rst", 0, codec_reset_out);
         irq_vector_reg <= 8'h16;
         wr(3);
         cyc(1);
         chk("flag", brow[i].flag, usb_reset_flag);
         irq_vector_reg <= `UREB_RST_VECTOR;
         wr(3);
         cyc(1);
         chk("flag", 0, usb_reset_flag);
      end
      seen_sys = 1'b0;
      host_u.master_reset();
      chk("sys_rst_seen", 1, seen_sys);
      chk("attach", 0, {bus_attach_bit, dp_pullup_oe});
      chk("codec_rst", 0, codec_reset_out);
      foreach (boot[i]) begin
         {eeprom_present, header_valid} <= {boot[i].pres, boot[i].vld};
         header_data_type <= boot[i].dt;
         wr(4);
         cyc(1);
         chk("boot_mode", boot[i].md, boot_mode);
         chk("enum_id", boot[i].hdr ? {HVID, HPID} : {DVID, DPID},
            {enum_vid, enum_pid});
      end
      {dl_to_eeprom, dl_attributes} <= {1'b1, 8'h02};
      run_dl();
      chk("dl_order", {UREB_DL_WR_HEADER, UREB_DL_SAVE_TYPE, UREB_DL_MARK, UREB_DL_WR_APP,
         UREB_DL_RESTORE, UREB_DL_IDLE}, seq);
      {dl_to_eeprom, dl_attributes, step_dly} <= {1'b0, 8'h00, 8'h04};
      run_dl();
      chk("dl_order", {UREB_DL_SAVE_TYPE, UREB_DL_MARK, UREB_DL_WR_APP, UREB_DL_RESTORE,
         UREB_DL_IDLE}, seq);
      step_dly <= 8'h3C;
      wr(5);
      for (n = 0; n < 500 && dl_state !== UREB_DL_WR_APP; n++) cyc(1);
      wr(6);
      cyc(1);
      chk("abort", {UREB_DL_IDLE, UREB_BOOT_UPGRADE_HEADER}, {dl_state, boot_mode});
      step_dly <= 8'h01;
      run_dl();
      chk("dl_order", {UREB_DL_RESTORE, UREB_DL_IDLE}, seq[5:0]);
      host_u.bus_reset();
      chk("boot_mode", UREB_BOOT_APPLICATION, boot_mode);
      seq = 24'h0;
      wr(5);
      cyc(2);
      chk("refused", 0, seq);
      end_of_test();
   end
endmodule : ureb_ctrl_tb_top
